/* rtl/osw_consts.vh */
// register indices, field positions, reset values and timing counts for the offset/status bank
`ifndef OSW_CONSTS_VH
`define OSW_CONSTS_VH

// register indices; byte address is four times the index
`define OSW_IDX_CHOFS_FIRST 9'h09e
`define OSW_IDX_CHOFS_LAST  9'h0a5
`define OSW_IDX_SCALE       9'h0a7
`define OSW_IDX_STARTUP     9'h0c0
`define OSW_IDX_PLL         9'h0d1
`define OSW_IDX_IDENT_LO    9'h15c
`define OSW_IDX_IDENT_HI    9'h15d
`define OSW_IDX_CTRL        9'h180
`define OSW_IDX_IRQ_STAT    9'h181
`define OSW_IDX_IRQ_MASK    9'h182

// offset_scale_ctrl
`define OSW_SCALE_RST       8'h47
`define OSW_SCALE_MSB       4
`define OSW_SCALE_LSB       3

// status bit positions
`define OSW_STARTUP_DONE    7
`define OSW_PLL_DONE        5
`define OSW_PLL_VCO_LOW     2
`define OSW_PLL_VCO_HIGH    1

// ctrl register bits
`define OSW_CTRL_PP_EN      0
`define OSW_CTRL_PLL_REQ    1

// interrupt events
`define OSW_EV_STARTUP      0
`define OSW_EV_PLL_DONE     1
`define OSW_EV_VCO_LOW      2
`define OSW_EV_VCO_HIGH     3
`define OSW_EV_BG_CAL       4
`define OSW_EV_W            5

// timing, in sample clock cycles
`define OSW_STARTUP_CYC     134217728
`define OSW_BG_CYC          1073741824
`define OSW_BASE_LAT        2
`define OSW_PP_LAT          2

`endif

/* rtl/osw_regs.v */
// offset-weight, calibration status and identification registers with the offset datapath
// How it works
// - scale bits 4..3 pick offset step 1/4, 1/2, 1 or 2 LSb; reset 00
// - one scale setting applies to every channel offset register 0x9e..0xa5
// - channel offset code is signed, scaled, then added to that channel's output
// - startup status bit 7 reads 0 until power-up calibration ends, then 1
// - startup status bits 6..0 are read-only factory bits, writes ignored
// - pll status bit 5 is 1 once pll calibration completes, else 0
// - pll status bit 2 flags drift out of lock with low vco frequency
// - pll status bit 1 flags drift out of lock with high vco frequency
// - pll status is read-only; factory bits 7..6, 4..3, 0 readable only
// - sixteen-bit part ident read as low byte 0x15c, high byte 0x15d
// - ident registers are read-only and fixed; writes change nothing
// - power-up calibration finishes within 2^27 sample clocks
// - background calibration updates about every 2^30 clocks while converting
// - a new output sample every clock, delayed by pipeline plus output delay
// - enabling post-processing lengthens output latency
//
// The AHB-Lite interface to the registers was left to the implementer.
`include "osw_consts.vh"
`default_nettype none

module osw_regs #(
  parameter        STARTUP_CYC = `OSW_STARTUP_CYC,
  parameter        BG_CYC      = `OSW_BG_CYC,
  parameter        BASE_LAT    = `OSW_BASE_LAT,
  parameter        PP_LAT      = `OSW_PP_LAT,
  parameter [15:0] PART_IDENT  = 16'h5a3c, // arbitrary value
  parameter [7:0]  STARTUP_FTB = 8'h00,
  parameter [7:0]  PLL_FTB     = 8'h00
) (
  // clock, reset, enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // pll status from the analog side, asynchronous
  input  wire        pll_cal_done_in,
  input  wire        vco_low_drift_in,
  input  wire        vco_high_drift_in,
  // converter samples, same clock
  input  wire [15:0] smp_data,
  input  wire [2:0]  smp_chan,
  // corrected output
  output reg  [15:0] out_data,
  output reg  [2:0]  out_chan,
  // control toward the core
  output reg         pll_cal_request,
  output reg         bg_cal_update,
  output reg         irq
);

  localparam TOT_LAT = BASE_LAT + PP_LAT;

  // bus state
  reg        wr_pend_ff;
  reg [8:0]  wr_idx_ff;
  reg        rd_pend_ff;
  reg [8:0]  rd_idx_ff;
  reg [31:0] nxt_rdata;
  wire       addr_ok = hsel & hready & htrans[1];
  wire [8:0] a_idx   = haddr[10:2];

  // registers
  reg [7:0]  scale_ff;
  reg [7:0]  chofs_ff [0:7];
  reg        pp_en_ff;
  reg [4:0]  irq_stat_ff;
  reg [4:0]  irq_mask_ff;
  reg        startup_done_ff;
  reg        pll_done_ff;
  reg        vco_low_ff;
  reg        vco_high_ff;
  reg [29:0] startup_cnt_ff;
  reg [30:0] bg_cnt_ff;

  // synchronisers: stage a feeds stage b only
  reg [2:0]  sync_a_ff;
  reg [2:0]  sync_b_ff;
  reg [2:0]  sync_q_ff;
  wire [2:0] rise = sync_b_ff & ~sync_q_ff;

  // datapath pipeline
  reg [15:0] pipe_d_ff [0:TOT_LAT-1];
  reg [2:0]  pipe_c_ff [0:TOT_LAT-1];
  reg [18:0] sum_ff;
  reg [2:0]  sum_chan_ff;
  reg [18:0] nxt_smp_q;
  reg [17:0] nxt_ofs_q;
  reg [18:0] nxt_sum;
  reg [15:0] nxt_smp_out;
  reg [4:0]  nxt_irq_stat;
  reg        nxt_pll_done;
  reg [29:0] nxt_startup_cnt;
  reg [30:0] nxt_bg_cnt;
  integer    i;
  integer    j;

  wire       wr_now   = wr_pend_ff;
  wire       pll_req  = wr_now && wr_idx_ff == `OSW_IDX_CTRL && hwdata[`OSW_CTRL_PLL_REQ];
  wire       cnt_end  = startup_cnt_ff == STARTUP_CYC - 1;
  wire       bg_end   = bg_cnt_ff == BG_CYC - 1;
  wire [4:0] events;

  assign events[`OSW_EV_STARTUP]  = cnt_end & ~startup_done_ff;
  assign events[`OSW_EV_PLL_DONE] = rise[0];
  assign events[`OSW_EV_VCO_LOW]  = rise[1];
  assign events[`OSW_EV_VCO_HIGH] = rise[2];
  assign events[`OSW_EV_BG_CAL]   = startup_done_ff & bg_end;

  // offset in quarter-LSb units from signed code and scale field
  function [17:0] scaled_ofs;
    input [7:0] code;
    input [1:0] sel;
    reg   [17:0] ext;
    begin
      ext        = {{10{code[7]}}, code};
      scaled_ofs = ext << sel;
    end
  endfunction

  // clamp the sum, its two fraction bits already dropped, to a signed 16-bit sample
  function [15:0] sat16;
    input [17:0] v;
    begin
      if (v[17] && !(&v[16:15]))
        sat16 = 16'h8000;
      else if (!v[17] && (|v[16:15]))
        sat16 = 16'h7fff;
      else
        sat16 = v[15:0];
    end
  endfunction

  // true for the eight channel offset indices
  function is_chofs;
    input [8:0] idx;
    begin
      is_chofs = idx >= `OSW_IDX_CHOFS_FIRST && idx <= `OSW_IDX_CHOFS_LAST;
    end
  endfunction

  // channel number behind a channel offset index
  function [2:0] chofs_sel;
    input [8:0] idx;
    begin
      chofs_sel = idx[2:0] - 3'h6;
    end
  endfunction

  // quarter-lsb sum keeps one spare bit so full scale plus offset cannot wrap
  always @*
  begin
    nxt_smp_q   = {{3{smp_data[15]}}, smp_data} << 2;
    nxt_ofs_q   = scaled_ofs(chofs_ff[smp_chan],
                             scale_ff[`OSW_SCALE_MSB:`OSW_SCALE_LSB]);
    nxt_sum     = nxt_smp_q + {nxt_ofs_q[17], nxt_ofs_q};
    // dropping the two fraction bits rounds toward minus infinity
    nxt_smp_out = sat16({sum_ff[18], sum_ff[18:2]});
  end

  // interrupt status: an event in the cycle of a write-one clear still sets its bit
  always @*
  begin
    nxt_irq_stat = irq_stat_ff | events;
    if (wr_now && wr_idx_ff == `OSW_IDX_IRQ_STAT)
      nxt_irq_stat = (irq_stat_ff & ~hwdata[4:0]) | events;
  end

  // pll done flag: a done edge outranks a request landing in the same cycle
  always @*
  begin
    nxt_pll_done = pll_done_ff;
    if (rise[0])
      nxt_pll_done = 1'b1;
    else if (pll_req)
      nxt_pll_done = 1'b0;
  end

  // startup count stops with its flag; background count waits for that flag
  always @*
  begin
    nxt_startup_cnt = startup_cnt_ff;
    if (!startup_done_ff)
      nxt_startup_cnt = startup_cnt_ff + 30'h1;
    nxt_bg_cnt = bg_cnt_ff;
    if (startup_done_ff)
      nxt_bg_cnt = bg_end ? 31'h0 : bg_cnt_ff + 31'h1;
  end

  // read mux
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    if (is_chofs(rd_idx_ff))
      nxt_rdata[7:0] = chofs_ff[chofs_sel(rd_idx_ff)];
    else
      case (rd_idx_ff)
        `OSW_IDX_SCALE:
          nxt_rdata[7:0] = scale_ff;
        `OSW_IDX_STARTUP:
          nxt_rdata[7:0] = {startup_done_ff, STARTUP_FTB[6:0]};
        `OSW_IDX_PLL:
          nxt_rdata[7:0] = {PLL_FTB[7:6], pll_done_ff, PLL_FTB[4:3],
                            vco_low_ff, vco_high_ff, PLL_FTB[0]};
        `OSW_IDX_IDENT_LO:
          nxt_rdata[7:0] = PART_IDENT[7:0];
        `OSW_IDX_IDENT_HI:
          nxt_rdata[7:0] = PART_IDENT[15:8];
        `OSW_IDX_CTRL:
          nxt_rdata[`OSW_CTRL_PP_EN] = pp_en_ff;
        `OSW_IDX_IRQ_STAT:
          nxt_rdata[4:0] = irq_stat_ff;
        `OSW_IDX_IRQ_MASK:
          nxt_rdata[4:0] = irq_mask_ff;
        default:
          nxt_rdata = 32'h0000_0000;
      endcase
  end

  // ahb slave: writes take no wait, reads one wait so a write just before is seen
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 9'h000;
      rd_pend_ff <= 1'b0;
      rd_idx_ff  <= 9'h000;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
    else if (ce)
    begin
      hresp <= 1'b0;
      if (rd_pend_ff)
      begin
        hrdata     <= nxt_rdata;
        hreadyout  <= 1'b1;
        rd_pend_ff <= 1'b0;
        wr_pend_ff <= 1'b0;
      end
      else
      begin
        wr_pend_ff <= addr_ok & hwrite;
        wr_idx_ff  <= a_idx;
        rd_idx_ff  <= a_idx;
        if (addr_ok && !hwrite)
        begin
          rd_pend_ff <= 1'b1;
          hreadyout  <= 1'b0;
        end
      end
    end
  end

  // software registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scale_ff        <= `OSW_SCALE_RST;
      pp_en_ff        <= 1'b0;
      irq_mask_ff     <= 5'h00;
      irq_stat_ff     <= 5'h00;
      pll_cal_request <= 1'b0;
      irq             <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        chofs_ff[i] <= 8'h00;
    end
    else if (ce)
    begin
      pll_cal_request <= pll_req;
      if (wr_now)
      begin
        // whole byte stored; factory bits kept by host read-modify-write
        if (wr_idx_ff == `OSW_IDX_SCALE)
          scale_ff <= hwdata[7:0];
        if (is_chofs(wr_idx_ff))
          chofs_ff[chofs_sel(wr_idx_ff)] <= hwdata[7:0];
        if (wr_idx_ff == `OSW_IDX_CTRL)
          pp_en_ff <= hwdata[`OSW_CTRL_PP_EN];
        if (wr_idx_ff == `OSW_IDX_IRQ_MASK)
          irq_mask_ff <= hwdata[4:0];
        // status, pll and ident indices have no write path
      end
      irq_stat_ff <= nxt_irq_stat;
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // calibration counters and status flags
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      startup_cnt_ff  <= 30'h0;
      startup_done_ff <= 1'b0;
      bg_cnt_ff       <= 31'h0;
      bg_cal_update   <= 1'b0;
      pll_done_ff     <= 1'b0;
      vco_low_ff      <= 1'b0;
      vco_high_ff     <= 1'b0;
      sync_a_ff       <= 3'h0;
      sync_b_ff       <= 3'h0;
      sync_q_ff       <= 3'h0;
    end
    else if (ce)
    begin
      sync_a_ff <= {vco_high_drift_in, vco_low_drift_in, pll_cal_done_in};
      sync_b_ff <= sync_a_ff;
      sync_q_ff <= sync_b_ff;
      // sticky: only a power-on reset clears it
      startup_cnt_ff <= nxt_startup_cnt;
      if (!startup_done_ff && cnt_end)
        startup_done_ff <= 1'b1;
      // background period restarts only after the foreground pass
      bg_cal_update <= events[`OSW_EV_BG_CAL];
      bg_cnt_ff     <= nxt_bg_cnt;
      pll_done_ff   <= nxt_pll_done;
      vco_low_ff  <= sync_b_ff[1];
      vco_high_ff <= sync_b_ff[2];
    end
  end

  // offset add, then a tapped delay line; one sample in and out every clock
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sum_ff      <= 19'h0;
      sum_chan_ff <= 3'h0;
      out_data    <= 16'h0000;
      out_chan    <= 3'h0;
      for (j = 0; j < TOT_LAT; j = j + 1)
      begin
        pipe_d_ff[j] <= 16'h0000;
        pipe_c_ff[j] <= 3'h0;
      end
    end
    else if (ce)
    begin
      // every channel uses the same scale field
      sum_ff       <= nxt_sum;
      sum_chan_ff  <= smp_chan;
      pipe_d_ff[0] <= nxt_smp_out;
      pipe_c_ff[0] <= sum_chan_ff;
      for (j = 1; j < TOT_LAT; j = j + 1)
      begin
        pipe_d_ff[j] <= pipe_d_ff[j-1];
        pipe_c_ff[j] <= pipe_c_ff[j-1];
      end
      // extra taps when post-processing is on
      out_data <= pp_en_ff ? pipe_d_ff[TOT_LAT-1] : pipe_d_ff[BASE_LAT-1];
      out_chan <= pp_en_ff ? pipe_c_ff[TOT_LAT-1] : pipe_c_ff[BASE_LAT-1];
    end
  end

endmodule

`default_nettype wire

/* tb/osw_chk.sv */
// assertion checker for the offset/status register bank
`default_nettype none
module osw_chk #(
  parameter        STARTUP_CYC = 20,
  parameter [15:0] PART_IDENT  = 16'h0000
) (
  // clock, reset, enable
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  // ahb-lite slave
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // control pulses
  input wire logic        pll_cal_request,
  input wire logic        bg_cal_update
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] up_ff;
  // saturates so a long run never wraps back below the calibration period
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      up_ff <= 8'h00;
    else if (up_ff != 8'hff)
      up_ff <= up_ff + 8'h01;
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence take(w);
    hsel && hready && htrans[1] && ce && hwrite == w;
  endsequence
  sequence ctrl_req;
    take(1'b1) ##0 haddr == 12'h600 ##1 hwdata[1];
  endsequence
  read_wait_a: assert property (take(1'b0) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take(1'b1) |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  ident_lo_a: assert property (take(1'b0) ##0 haddr == 12'h570 |-> ##2 hrdata == {24'h0, PART_IDENT[7:0]})
    else $error("ident low byte wrong");
  ident_hi_a: assert property (take(1'b0) ##0 haddr == 12'h574 |-> ##2 hrdata == {24'h0, PART_IDENT[15:8]})
    else $error("ident high byte wrong");
  startup_done_a: assert property (take(1'b0) ##0 haddr == 12'h300 ##0 up_ff > STARTUP_CYC + 4 |-> ##2 hrdata[7])
    else $error("startup flag not set");
  bg_pulse_a: assert property (bg_cal_update |=> !bg_cal_update [*8])
    else $error("background update too often");
  req_pulse_a: assert property (ctrl_req |-> ##[0:2] pll_cal_request)
    else $error("pll request pulse missing");
  req_once_a: assert property (pll_cal_request |=> !pll_cal_request)
    else $error("pll request longer than one cycle");
endmodule
bind osw_regs osw_chk #(.STARTUP_CYC(STARTUP_CYC), .PART_IDENT(PART_IDENT)) osw_chk_i (
  .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
  .hreadyout, .hresp, .pll_cal_request, .bg_cal_update);
`default_nettype wire

/* tb/osw_host.sv */
// host bus master model issuing single ahb-lite word transfers
`default_nettype none
module osw_host (
  // clock
  input  wire logic        hclk,
  // ahb-lite master side
  output var  logic        hsel,
  output var  logic [11:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  // byte address is four times the register index
  task automatic xfer(input logic [8:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {1'b0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    // stale data must not look valid after the phase
    hwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

/* tb/osw_regs_tb.sv */
// self-checking bench for the offset/status register bank
`include "osw_consts.vh"
`default_nettype none
module osw_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] ID = 16'h1e93; // arbitrary value
  logic        hclk = 1'b0, hresetn = 1'b0, pll_in = 1'b0, vlo_in = 1'b0, vhi_in = 1'b0;
  logic        hsel, hwrite, hready, hresp, req, bgu, irq, pp = 1'b0, chk_en = 1'b0;
  logic [11:0] haddr;
  logic [1:0]  htrans, sc;
  logic [2:0]  hsize, smp_chan = 3'h0, out_chan;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] smp_data = 16'h0, out_data;
  logic [7:0]  code [8];
  logic [18:0] q [$];
  int          num_errors = 0, checked = 0;
  always #12.5 hclk = ~hclk;
  osw_regs #(.STARTUP_CYC(20), .BG_CYC(40), .PART_IDENT(ID)) osw_regs_i (
    .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hrdata, .hreadyout(hready), .hresp, .pll_cal_done_in(pll_in), .vco_low_drift_in(vlo_in),
    .vco_high_drift_in(vhi_in), .smp_data, .smp_chan, .out_data, .out_chan,
    .pll_cal_request(req), .bg_cal_update(bgu), .irq);
  osw_host osw_host_i (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata);
  task automatic give_verdict();
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [8:0] idx, input logic [31:0] exp);
    osw_host_i.xfer(idx, 1'b0, 32'h0, rd);
    cmp(rd, exp);
  endtask
  task automatic wr(input logic [8:0] idx, input logic [31:0] d);
    osw_host_i.xfer(idx, 1'b1, d, rd);
  endtask
  // sample and offset summed in quarter steps, fraction dropped toward minus infinity
  function automatic logic [15:0] corr(input logic [15:0] s, input logic [7:0] c,
                                       input logic [1:0] k);
    int v;
    v = ($signed(s) * 4 + $signed(c) * (1 << k)) >>> 2;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction
  always @(posedge hclk)
  begin
    smp_data <= 16'($urandom);
    smp_chan <= 3'($urandom);
    if (chk_en)
    begin
      q.push_back({smp_chan, corr(smp_data, code[smp_chan], sc)});
      if (q.size() > `OSW_BASE_LAT + 2 + (pp ? `OSW_PP_LAT : 0))
        cmp({13'h0, q.pop_front()}, {13'h0, out_chan, out_data});
    end
  end
  initial
  begin
    #75000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h335b8f9c));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`OSW_IDX_STARTUP, 32'h0);
    rd_chk(`OSW_IDX_SCALE, 32'h47);
    rd_chk(`OSW_IDX_PLL, 32'h0);
    wr(9'h0a6, 32'hff);
    rd_chk(9'h0a6, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      wr(`OSW_IDX_IDENT_LO, $urandom);
      wr(`OSW_IDX_IDENT_HI, $urandom);
      rd_chk(`OSW_IDX_IDENT_LO, {24'h0, ID[7:0]});
      rd_chk(`OSW_IDX_IDENT_HI, {24'h0, ID[15:8]});
    end
    // host waits out the calibration period before trusting data
    repeat (30) @(posedge hclk);
    wr(`OSW_IDX_STARTUP, 32'h7f);
    rd_chk(`OSW_IDX_STARTUP, 32'h80);
    for (int i = 0; i < 8; i++)
    begin
      {pll_in, vlo_in, vhi_in} <= 3'(i);
      repeat (4) @(posedge hclk);
      wr(`OSW_IDX_PLL, 32'hff);
      rd_chk(`OSW_IDX_PLL, {26'h0, i[2], 2'b0, i[1], i[0], 1'b0});
    end
    wr(`OSW_IDX_CTRL, 32'h2);
    pll_in <= 1'b0;
    repeat (4) @(posedge hclk);
    pll_in <= 1'b1;
    repeat (4) @(posedge hclk);
    rd_chk(`OSW_IDX_PLL, 32'h26);
    for (int k = 0; k < 8; k++)
    begin
      chk_en <= 1'b0;
      sc = k[1:0];
      pp <= k[2];
      osw_host_i.xfer(`OSW_IDX_SCALE, 1'b0, 32'h0, rd);
      wr(`OSW_IDX_SCALE, {rd[31:5], sc, rd[2:0]});
      wr(`OSW_IDX_CTRL, {31'h0, k[2]});
      for (int c = 0; c < 8; c++)
      begin
        code[c] = (c == k) ? 8'h80 : 8'($urandom);
        wr(`OSW_IDX_CHOFS_FIRST + 9'(c), {24'h0, code[c]});
      end
      q.delete();
      chk_en <= 1'b1;
      repeat (40) @(posedge hclk);
    end
    chk_en <= 1'b0;
    wr(`OSW_IDX_IRQ_MASK, 32'h0);
    osw_host_i.xfer(`OSW_IDX_IRQ_STAT, 1'b0, 32'h0, rd);
    cmp({31'h0, rd[0]}, 32'h1);
    repeat (3) @(posedge hclk);
    cmp({31'h0, irq}, 32'h0);
    wr(`OSW_IDX_IRQ_MASK, 32'h1);
    repeat (3) @(posedge hclk);
    cmp({31'h0, irq}, 32'h1);
    wr(`OSW_IDX_IRQ_STAT, 32'h1);
    repeat (3) @(posedge hclk);
    cmp({31'h0, irq}, 32'h0);
    wr(`OSW_IDX_IRQ_MASK, 32'h10);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge hclk);
    cmp({31'h0, irq}, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
